// [src/ets56_top.sv]
// The AHB-Lite slave port was left to the implementer.
`include "ets56_regs.svh"
`default_nettype none

// What this block does
// R1 - Sample registers show the unit chosen by bit 8 of the unit index.
// R2 - Nanoseconds bit 30 reads 1 for a rising edge, 0 for falling.
// R3 - Fifth-sample nanoseconds bits 29:0 hold the fifth event's nanoseconds.
// R4 - Sixth-sample nanoseconds bits 29:0 hold the sixth event's nanoseconds.
// R5 - Fifth-sample seconds register holds the fifth event's full seconds.
// R6 - Sixth-sample seconds register holds the sixth event's full seconds.
// R7 - Phase bits 2:0 name the 8ns slot inside the 40ns period.
// R8 - Third slot code clashes with reserved 101; resolved as code 010.
// R9 - Reserved bits of nanoseconds and phase registers always read zero.
// R10 - All six sample registers are read-only; writes change nothing.
module ets56_top
    import ets56_pkg::*;
#(
    parameter int NUM_UNITS = 2,
    parameter int UNIT_W    = (NUM_UNITS > 1) ? $clog2(NUM_UNITS) : 1
) (
    input  wire logic                   mclk_i,
    input  wire logic                   rstn_i,
    input  wire logic                   hsel_i,
    input  wire logic [31:0]            haddr_i,
    input  wire logic [1:0]             htrans_i,
    input  wire logic                   hwrite_i,
    input  wire logic [2:0]             hsize_i,
    input  wire logic [31:0]            hwdata_i,
    input  wire logic                   hready_i,
    output logic      [31:0]            hrdata_o,
    output logic                        hreadyout_o,
    output logic                        hresp_o,
    input  wire logic [31:0]            unit_index_i,
    input  wire logic                   cap_valid_i,
    input  wire logic                   cap_sample_i,
    input  wire logic [UNIT_W-1:0]      cap_unit_i,
    input  wire logic                   cap_rising_i,
    input  wire logic [`ETS_NS_W-1:0]   cap_ns_i,
    input  wire logic [`ETS_SEC_W-1:0]  cap_sec_i,
    input  wire logic [`ETS_SLOT_W-1:0] cap_slot_i
);

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic ets_reg_type decode_reg(
        input logic [31:0] addr
    );
        logic [`ETS_OFS_W-1:0] ofs;
        ofs = addr[`ETS_OFS_W-1:0];
        decode_reg = ETS_REG_NONE;
        if (addr[31:`ETS_OFS_W] == '0) begin
            unique case (ofs)
                `ETS_OFS_S5_NS:    decode_reg = ETS_REG_S5_NS;
                `ETS_OFS_S5_SEC:   decode_reg = ETS_REG_S5_SEC;
                `ETS_OFS_S5_PHASE: decode_reg = ETS_REG_S5_PHASE;
                `ETS_OFS_S6_NS:    decode_reg = ETS_REG_S6_NS;
                `ETS_OFS_S6_SEC:   decode_reg = ETS_REG_S6_SEC;
                `ETS_OFS_S6_PHASE: decode_reg = ETS_REG_S6_PHASE;
                default:           decode_reg = ETS_REG_NONE;
            endcase
        end
    endfunction : decode_reg

    function automatic logic [31:0] pack_ns(
        input logic                 rising,
        input logic [`ETS_NS_W-1:0] ns
    );
        pack_ns = {{`ETS_RESERVED_NS_W{1'b0}}, rising, ns}; // R9
    endfunction : pack_ns

    function automatic logic [31:0] pack_phase(
        input logic [`ETS_PHASE_W-1:0] code
    );
        pack_phase = {{`ETS_RESERVED_PH_W{1'b0}}, code}; // R9
    endfunction : pack_phase

    // ------------------------------------------------------------
    // Capture stage
    // ------------------------------------------------------------
    logic                    cap_valid_reg;
    logic                    cap_sample_reg;
    logic [UNIT_W-1:0]       cap_unit_reg;
    logic                    cap_rising_reg;
    logic [`ETS_NS_W-1:0]    cap_ns_reg;
    logic [`ETS_SEC_W-1:0]   cap_sec_reg;
    logic [`ETS_PHASE_W-1:0] cap_phase_reg;
    logic [`ETS_PHASE_W-1:0] enc_code;
    logic                    enc_valid;

    ets56_phase_encode u_phase_encode (
        .slot_i  (cap_slot_i),
        .code_o  (enc_code),
        .valid_o (enc_valid)
    );

    // An out-of-range slot is dropped, so a reserved code never lands in storage
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cap_valid_reg <= 1'b0;
        end else begin
            cap_valid_reg <= cap_valid_i & enc_valid;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cap_sample_reg <= 1'b0;
            cap_unit_reg   <= '0;
            cap_rising_reg <= 1'b0;
            cap_ns_reg     <= `ETS_RESET_NS;
            cap_sec_reg    <= `ETS_RESET_WORD;
            cap_phase_reg  <= `ETS_RESET_PHASE;
        end else if (cap_valid_i) begin
            cap_sample_reg <= cap_sample_i;
            cap_unit_reg   <= cap_unit_i;
            cap_rising_reg <= cap_rising_i; // R2
            cap_ns_reg     <= cap_ns_i;
            cap_sec_reg    <= cap_sec_i;
            cap_phase_reg  <= enc_code; // R7
        end
    end

    // ------------------------------------------------------------
    // Sample storage
    // ------------------------------------------------------------
    logic                    wr5_en;
    logic                    wr6_en;
    logic [UNIT_W-1:0]       rd_unit;
    logic                    s5_rising;
    logic [`ETS_NS_W-1:0]    s5_ns;
    logic [`ETS_SEC_W-1:0]   s5_sec;
    logic [`ETS_PHASE_W-1:0] s5_phase;
    logic                    s6_rising;
    logic [`ETS_NS_W-1:0]    s6_ns;
    logic [`ETS_SEC_W-1:0]   s6_sec;
    logic [`ETS_PHASE_W-1:0] s6_phase;

    assign wr5_en  = cap_valid_reg & (cap_sample_reg == ETS_SAMPLE5);
    assign wr6_en  = cap_valid_reg & (cap_sample_reg == ETS_SAMPLE6);
    // Index register lives elsewhere; only its unit pointer bit is used
    assign rd_unit = UNIT_W'(unit_index_i[`ETS_UNIT_INDEX_BIT]); // R1

    ets56_sample_store #(
        .NUM_UNITS (NUM_UNITS),
        .UNIT_W    (UNIT_W)
    ) u_store5 (
        .mclk_i      (mclk_i),
        .rstn_i      (rstn_i),
        .wr_en_i     (wr5_en),
        .wr_unit_i   (cap_unit_reg),
        .wr_rising_i (cap_rising_reg),
        .wr_ns_i     (cap_ns_reg),
        .wr_sec_i    (cap_sec_reg),
        .wr_phase_i  (cap_phase_reg),
        .rd_unit_i   (rd_unit),
        .rd_rising_o (s5_rising),
        .rd_ns_o     (s5_ns),
        .rd_sec_o    (s5_sec),
        .rd_phase_o  (s5_phase)
    );

    ets56_sample_store #(
        .NUM_UNITS (NUM_UNITS),
        .UNIT_W    (UNIT_W)
    ) u_store6 (
        .mclk_i      (mclk_i),
        .rstn_i      (rstn_i),
        .wr_en_i     (wr6_en),
        .wr_unit_i   (cap_unit_reg),
        .wr_rising_i (cap_rising_reg),
        .wr_ns_i     (cap_ns_reg),
        .wr_sec_i    (cap_sec_reg),
        .wr_phase_i  (cap_phase_reg),
        .rd_unit_i   (rd_unit),
        .rd_rising_o (s6_rising),
        .rd_ns_o     (s6_ns),
        .rd_sec_o    (s6_sec),
        .rd_phase_o  (s6_phase)
    );

    // ------------------------------------------------------------
    // AHB-Lite address phase
    // ------------------------------------------------------------
    logic        addr_take;
    logic        rd_take;
    ets_reg_type rd_sel;

    assign addr_take = hsel_i & hready_i & htrans_i[1];
    // Writes are accepted with OKAY but never reach storage
    assign rd_take   = addr_take & ~hwrite_i; // R10
    assign rd_sel    = (hsize_i == `ETS_HSIZE_WORD) ? decode_reg(haddr_i) : ETS_REG_NONE;

    // ------------------------------------------------------------
    // Read data, loaded at the address edge
    // ------------------------------------------------------------
    // Data reflects storage at the address edge; a capture in that
    // same cycle shows up on the next read
    logic [31:0] hrdata_next;

    always_comb begin
        hrdata_next = `ETS_RESET_WORD;
        unique case (rd_sel)
            ETS_REG_S5_NS:    hrdata_next = pack_ns(s5_rising, s5_ns); // R3
            ETS_REG_S5_SEC:   hrdata_next = s5_sec; // R5
            ETS_REG_S5_PHASE: hrdata_next = pack_phase(s5_phase); // R7
            ETS_REG_S6_NS:    hrdata_next = pack_ns(s6_rising, s6_ns); // R4
            ETS_REG_S6_SEC:   hrdata_next = s6_sec; // R6
            ETS_REG_S6_PHASE: hrdata_next = pack_phase(s6_phase); // R7
            ETS_REG_NONE:     hrdata_next = `ETS_RESET_WORD;
            default:          hrdata_next = `ETS_RESET_WORD;
        endcase
    end

    logic [31:0] hrdata_reg;

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hrdata_reg <= `ETS_RESET_WORD;
        end else if (rd_take) begin
            hrdata_reg <= hrdata_next; // R1
        end else if (addr_take) begin
            hrdata_reg <= `ETS_RESET_WORD;
        end
    end

    // ------------------------------------------------------------
    // Response: zero wait states, always OKAY
    // ------------------------------------------------------------
    logic hreadyout_reg;
    logic hresp_reg;

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hreadyout_reg <= 1'b1;
            hresp_reg     <= 1'b0;
        end else begin
            hreadyout_reg <= 1'b1;
            hresp_reg     <= 1'b0;
        end
    end

    assign hrdata_o    = hrdata_reg;
    assign hreadyout_o = hreadyout_reg;
    assign hresp_o     = hresp_reg;

endmodule : ets56_top

`default_nettype wire

// [src/ets56_regs.svh]
`ifndef ETS56_REGS_SVH
`define ETS56_REGS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ETS_OFS_S5_NS      12'h584
`define ETS_OFS_S5_SEC     12'h588
`define ETS_OFS_S5_PHASE   12'h58c
`define ETS_OFS_S6_NS      12'h590
`define ETS_OFS_S6_SEC     12'h594
`define ETS_OFS_S6_PHASE   12'h598
`define ETS_OFS_W          12

// ----------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------
`define ETS_UNIT_INDEX_BIT 8
`define ETS_EDGE_BIT       30
`define ETS_NS_W           30
`define ETS_SEC_W          32
`define ETS_PHASE_W        3
`define ETS_SLOT_W         3
`define ETS_RESERVED_NS_W  1
`define ETS_RESERVED_PH_W  29

// ----------------------------------------------------------------
// Reset values and sub-slot codes
// ----------------------------------------------------------------
`define ETS_RESET_WORD     32'h0000_0000
`define ETS_RESET_NS       30'h0000_0000
`define ETS_RESET_PHASE    3'h0
`define ETS_PHASE_SLOT0    3'h0
`define ETS_PHASE_SLOT1    3'h1
`define ETS_PHASE_SLOT2    3'h2
`define ETS_PHASE_SLOT3    3'h3
`define ETS_PHASE_SLOT4    3'h4
`define ETS_HSIZE_WORD     3'h2

`endif

// [src/ets56_pkg.sv]
`default_nettype none

package ets56_pkg;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ETS_HTRANS_IDLE   = 2'b00,
        ETS_HTRANS_BUSY   = 2'b01,
        ETS_HTRANS_NONSEQ = 2'b10,
        ETS_HTRANS_SEQ    = 2'b11
    } ets_htrans_type;

    typedef enum logic [0:0] {
        ETS_SAMPLE5 = 1'b0,
        ETS_SAMPLE6 = 1'b1
    } ets_sample_type;

    typedef enum logic [2:0] {
        ETS_REG_NONE     = 3'b000,
        ETS_REG_S5_NS    = 3'b001,
        ETS_REG_S5_SEC   = 3'b010,
        ETS_REG_S5_PHASE = 3'b011,
        ETS_REG_S6_NS    = 3'b100,
        ETS_REG_S6_SEC   = 3'b101,
        ETS_REG_S6_PHASE = 3'b110
    } ets_reg_type;

endpackage : ets56_pkg

`default_nettype wire

// [src/ets56_phase_encode.sv]
`include "ets56_regs.svh"
`default_nettype none

module ets56_phase_encode
    import ets56_pkg::*;
(
    input  wire logic [`ETS_SLOT_W-1:0]  slot_i,
    output logic      [`ETS_PHASE_W-1:0] code_o,
    output logic                         valid_o
);

    // ------------------------------------------------------------
    // Slot to code
    // ------------------------------------------------------------
    // Third slot takes 010 so that 101-111 stay reserved
    function automatic logic [`ETS_PHASE_W-1:0] slot_code(
        input logic [`ETS_SLOT_W-1:0] slot
    );
        unique case (slot)
            3'd0:    slot_code = `ETS_PHASE_SLOT0; // R7
            3'd1:    slot_code = `ETS_PHASE_SLOT1; // R7
            3'd2:    slot_code = `ETS_PHASE_SLOT2; // R8
            3'd3:    slot_code = `ETS_PHASE_SLOT3; // R7
            3'd4:    slot_code = `ETS_PHASE_SLOT4; // R7
            default: slot_code = `ETS_RESET_PHASE;
        endcase
    endfunction : slot_code

    assign code_o  = slot_code(slot_i);
    assign valid_o = (slot_i <= `ETS_PHASE_SLOT4);

endmodule : ets56_phase_encode

`default_nettype wire

// [src/ets56_sample_store.sv]
`include "ets56_regs.svh"
`default_nettype none

module ets56_sample_store
    import ets56_pkg::*;
#(
    parameter int NUM_UNITS = 2,
    parameter int UNIT_W    = (NUM_UNITS > 1) ? $clog2(NUM_UNITS) : 1
) (
    input  wire logic                    mclk_i,
    input  wire logic                    rstn_i,
    input  wire logic                    wr_en_i,
    input  wire logic [UNIT_W-1:0]       wr_unit_i,
    input  wire logic                    wr_rising_i,
    input  wire logic [`ETS_NS_W-1:0]    wr_ns_i,
    input  wire logic [`ETS_SEC_W-1:0]   wr_sec_i,
    input  wire logic [`ETS_PHASE_W-1:0] wr_phase_i,
    input  wire logic [UNIT_W-1:0]       rd_unit_i,
    output logic                         rd_rising_o,
    output logic      [`ETS_NS_W-1:0]    rd_ns_o,
    output logic      [`ETS_SEC_W-1:0]   rd_sec_o,
    output logic      [`ETS_PHASE_W-1:0] rd_phase_o
);

    logic                    rising_reg [NUM_UNITS];
    logic [`ETS_NS_W-1:0]    ns_reg     [NUM_UNITS];
    logic [`ETS_SEC_W-1:0]   sec_reg    [NUM_UNITS];
    logic [`ETS_PHASE_W-1:0] phase_reg  [NUM_UNITS];

    // ------------------------------------------------------------
    // Capture storage, one entry per unit; only capture logic writes
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (int u = 0; u < NUM_UNITS; u++) begin
                rising_reg[u] <= 1'b0;
                ns_reg[u]     <= `ETS_RESET_NS;
                sec_reg[u]    <= `ETS_RESET_WORD;
                phase_reg[u]  <= `ETS_RESET_PHASE;
            end
        end else if (wr_en_i) begin
            rising_reg[wr_unit_i] <= wr_rising_i; // R2
            ns_reg[wr_unit_i]     <= wr_ns_i;
            sec_reg[wr_unit_i]    <= wr_sec_i;
            phase_reg[wr_unit_i]  <= wr_phase_i;
        end
    end

    assign rd_rising_o = rising_reg[rd_unit_i];
    assign rd_ns_o     = ns_reg[rd_unit_i];
    assign rd_sec_o    = sec_reg[rd_unit_i];
    assign rd_phase_o  = phase_reg[rd_unit_i];

endmodule : ets56_sample_store

`default_nettype wire

// [tb/ets56_checker.sv]
`include "ets56_regs.svh"
`default_nettype none

module ets56_checker
    import ets56_pkg::*;
#(
    parameter int NUM_UNITS = 2,
    parameter int UNIT_W    = 1
) (
    input wire logic              mclk_i,
    input wire logic              rstn_i,
    input wire logic              hsel_i,
    input wire logic [31:0]       haddr_i,
    input wire logic [1:0]        htrans_i,
    input wire logic              hwrite_i,
    input wire logic [2:0]        hsize_i,
    input wire logic              hready_i,
    input wire logic [31:0]       hrdata_o,
    input wire logic              hreadyout_o,
    input wire logic              hresp_o,
    input wire logic [31:0]       unit_index_i,
    input wire logic              cap_valid_i,
    input wire logic              cap_sample_i,
    input wire logic [UNIT_W-1:0] cap_unit_i,
    input wire logic              cap_rising_i,
    input wire logic [29:0]       cap_ns_i,
    input wire logic [31:0]       cap_sec_i,
    input wire logic [2:0]        cap_slot_i
);
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    logic acc, cap, ns_rd, ph_rd, unm_rd;
    assign acc   = hsel_i && hready_i && htrans_i[1];
    assign unm_rd = acc && haddr_i[31:12] != 20'h0_0000;
    assign cap   = cap_valid_i && cap_slot_i <= 3'h4;
    assign ns_rd = acc && (haddr_i == 32'h0000_0584 || haddr_i == 32'h0000_0590);
    assign ph_rd = acc && (haddr_i == 32'h0000_058c || haddr_i == 32'h0000_0598);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);

    // A read of one field of the captured sample, on the unit that was captured
    sequence rd_at(logic [11:0] o, logic u);
        acc && !hwrite_i && hsize_i == `ETS_HSIZE_WORD && haddr_i == {20'h0_0000, o}
            && unit_index_i[8] == u;
    endsequence

    // Local variables live in named properties; an inline assert cannot declare them
    property p_ns_shown;
        logic [31:0] w;
        logic [11:0] o;
        logic        u;
        (cap, w = {1'b0, cap_rising_i, cap_ns_i}, o = cap_sample_i ? 12'h590 : 12'h584,
         u = cap_unit_i[0]) ##2 rd_at(o, u) |=> hrdata_o == w;
    endproperty

    property p_sec_shown;
        logic [31:0] w;
        logic [11:0] o;
        logic        u;
        (cap, w = cap_sec_i, o = cap_sample_i ? 12'h594 : 12'h588, u = cap_unit_i[0])
        ##1 (!cap_valid_i)[*3] ##1 rd_at(o, u) |=> hrdata_o == w;
    endproperty

    property p_phase_shown;
        logic [2:0]  w;
        logic [11:0] o;
        logic        u;
        (cap, w = cap_slot_i, o = cap_sample_i ? 12'h598 : 12'h58c, u = cap_unit_i[0])
        ##1 (!cap_valid_i)[*5] ##1 rd_at(o, u) |=> hrdata_o == {29'h0, w};
    endproperty

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    a_ns_top_zero: assert property (ns_rd |=> !hrdata_o[31])
        else $error("nanoseconds bit 31 not zero");
    a_phase_high_zero: assert property (ph_rd |=> hrdata_o[31:3] == 29'h0)
        else $error("phase upper bits not zero");
    a_phase_code_legal: assert property (ph_rd |=> hrdata_o[2:0] <= 3'h4)
        else $error("phase code out of range");
    a_write_reads_zero: assert property (acc && hwrite_i |=> hrdata_o == 32'h0000_0000)
        else $error("write returned data");
    a_unmapped_reads_zero: assert property (unm_rd |=> hrdata_o == 32'h0000_0000)
        else $error("unmapped read returned data");
    a_okay_only: assert property (hresp_o == 1'b0)
        else $error("response not okay");
    a_ready_high: assert property (hreadyout_o == 1'b1)
        else $error("ready not high");
    a_capture_ns_shown: assert property (p_ns_shown)
        else $error("captured nanoseconds not shown");
    a_capture_sec_shown: assert property (p_sec_shown)
        else $error("captured seconds not shown");
    a_capture_phase_shown: assert property (p_phase_shown)
        else $error("captured phase not shown");

    c_capture_read: cover property (cap ##2 ns_rd);
    c_write: cover property (acc && hwrite_i);
    c_dropped: cover property (cap_valid_i && cap_slot_i > 3'h4);
endmodule : ets56_checker

bind ets56_top ets56_checker #(.NUM_UNITS(NUM_UNITS), .UNIT_W(UNIT_W)) ets56_checker_i (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hready_i(hready_i),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .unit_index_i(unit_index_i),
    .cap_valid_i(cap_valid_i), .cap_sample_i(cap_sample_i), .cap_unit_i(cap_unit_i),
    .cap_rising_i(cap_rising_i), .cap_ns_i(cap_ns_i), .cap_sec_i(cap_sec_i),
    .cap_slot_i(cap_slot_i));

`default_nettype wire

// [tb/ets56_event_src.sv]
`default_nettype none

module ets56_event_src #(
    parameter int UNIT_W = 1
) (
    input  wire logic              mclk_i,
    output logic                   cap_valid_o,
    output logic                   cap_sample_o,
    output logic      [UNIT_W-1:0] cap_unit_o,
    output logic                   cap_rising_o,
    output logic      [29:0]       cap_ns_o,
    output logic      [31:0]       cap_sec_o,
    output logic      [2:0]        cap_slot_o
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        cap_valid_o = 1'b0;
        {cap_sample_o, cap_unit_o, cap_rising_o, cap_ns_o, cap_sec_o, cap_slot_o} = '0;
    end

    // One capture pulse, then a settling cycle before the caller reads
    task automatic fire(input logic s, input logic [UNIT_W-1:0] u, input logic r,
                        input logic [29:0] n, input logic [31:0] sec, input logic [2:0] sl);
        @(posedge mclk_i);
        cap_valid_o <= 1'b1;
        {cap_sample_o, cap_unit_o, cap_rising_o, cap_ns_o, cap_sec_o, cap_slot_o}
            <= {s, u, r, n, sec, sl};
        @(posedge mclk_i);
        cap_valid_o <= 1'b0;
        // Data is not held after the pulse: inverted so a late sample is caught
        {cap_sample_o, cap_unit_o, cap_rising_o, cap_ns_o, cap_sec_o, cap_slot_o}
            <= ~{s, u, r, n, sec, sl};
        @(posedge mclk_i);
    endtask : fire
endmodule : ets56_event_src

`default_nettype wire

// [tb/ets56_bench.sv]
`include "ets56_regs.svh"
`default_nettype none

module ets56_bench
    import ets56_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic        mclk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, unit_index = 32'h0000_0000;
    logic [1:0]  htrans = ETS_HTRANS_IDLE;
    logic [2:0]  hsize = `ETS_HSIZE_WORD;
    logic [31:0] hrdata;
    logic        hreadyout, hresp, cap_valid, cap_sample, cap_unit, cap_rising;
    logic [29:0] cap_ns;
    logic [31:0] cap_sec;
    logic [2:0]  cap_slot;
    logic [31:0] mdl [2][2][3];
    logic [31:0] unm [3] = '{32'h0000_059c, 32'h0000_1584, 32'h8000_0590};
    int          errors = 0;
    int          comparisons = 0;

    always #2.5 mclk = ~mclk;

    ets56_event_src #(.UNIT_W(1)) ets56_event_src_i (
        .mclk_i(mclk), .cap_valid_o(cap_valid), .cap_sample_o(cap_sample),
        .cap_unit_o(cap_unit), .cap_rising_o(cap_rising), .cap_ns_o(cap_ns),
        .cap_sec_o(cap_sec), .cap_slot_o(cap_slot));
    ets56_top #(.NUM_UNITS(2)) ets56_top_i (
        .mclk_i(mclk), .rstn_i(rstn), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hreadyout),
        .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
        .unit_index_i(unit_index), .cap_valid_i(cap_valid), .cap_sample_i(cap_sample),
        .cap_unit_i(cap_unit), .cap_rising_i(cap_rising), .cap_ns_i(cap_ns),
        .cap_sec_i(cap_sec), .cap_slot_i(cap_slot));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : check

    // No wait count is assumed here; only the watchdog ends a stuck bus
    task automatic wait_ready;
        do begin
            @(posedge mclk);
        end while (hreadyout !== 1'b1);
    endtask : wait_ready

    task automatic bus(input logic wr, input logic [31:0] ad, output logic [31:0] rd);
        hsel   <= 1'b1;
        haddr  <= ad;
        htrans <= ETS_HTRANS_NONSEQ;
        hwrite <= wr;
        wait_ready();
        htrans <= ETS_HTRANS_IDLE;
        hwdata <= $urandom;
        wait_ready();
        rd = hrdata;
    endtask : bus

    // Random upper bits in the index word must not disturb the unit choice
    task automatic read_sample(input int u, input int s);
        logic [31:0] d;
        unit_index <= ($urandom & 32'hffff_feff) | (32'(u) << 8);
        for (int f = 0; f < 3; f++) begin
            bus(1'b0, 32'h0000_0584 + 32'(s * 12 + f * 4), d);
            check(mdl[u][s][f], d);
        end
    endtask : read_sample

    task automatic read_all;
        for (int u = 0; u < 2; u++) begin
            for (int s = 0; s < 2; s++) read_sample(u, s);
        end
    endtask : read_all

    task automatic results;
        $display("comparisons=%0d errors=%0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        logic [31:0] d, sec;
        logic [29:0] ns;
        logic        r;
        int          u, s, sl;
        mdl = '{default: 32'h0000_0000};
        repeat (6) @(posedge mclk);
        rstn <= 1'b1;
        void'($urandom(31786));
        read_all();
        $display("test reset_values done");
        // Slots 5..7 land on samples too: those captures must be dropped
        for (int i = 0; i < 32; i++) begin
            s = $urandom_range(1, 0);
            u = $urandom_range(1, 0);
            sl = i % 8;
            r = 1'($urandom);
            ns = 30'($urandom);
            sec = $urandom;
            ets56_event_src_i.fire(1'(s), 1'(u), r, ns, sec, 3'(sl));
            if (sl <= 4) begin
                mdl[u][s] = '{{1'b0, r, ns}, sec, 32'(sl)};
            end
            read_sample(u, s);
        end
        read_all();
        $display("test capture done");
        for (int a = 0; a < 6; a++) begin
            bus(1'b1, 32'h0000_0584 + 32'(a * 4), d);
            check(32'h0000_0000, d);
        end
        foreach (unm[k]) begin
            bus(1'b0, unm[k], d);
            check(32'h0000_0000, d);
        end
        read_all();
        $display("test write_unmapped done");
        @(posedge mclk);
        rstn <= 1'b0;
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        mdl = '{default: 32'h0000_0000};
        read_all();
        $display("test mid_reset done");
        results();
    end

    initial begin
        #50us;
        errors++;
        results();
    end
endmodule : ets56_bench

`default_nettype wire
